// [preset_cmd_if.sv]
// link between the controller sequencer and the counter module
`timescale 1ns/10ps
`default_nettype none
interface preset_cmd_if;
   import preset_cmd_pkg::*;
   logic req; // command valid, held until done
   cmd_t cmd; // command payload
   logic done; // one-cycle completion pulse
   logic ok; // accepted when done is high
   modport ctrl (output req, output cmd, input done, input ok);
   modport module_end (input req, input cmd, output done, output ok);
endinterface : preset_cmd_if
`default_nettype wire

// [preset_cmd_module.sv]
// counter module end: executes edit-and-reload and init-table commands
`timescale 1ns/10ps
`default_nettype none
`include "preset_cmd_regs.svh"
module preset_cmd_module
   import preset_cmd_pkg::*;
(
   input wire logic clk_sys, // scan clock
   input wire logic reset_n, // async reset, active low
   input wire logic [7:0] own_selector, // this module's number
   preset_cmd_if.module_end link, // from controller
   output logic table_load, // pulse: table applied to output
   output logic [1:0] load_output, // output being reloaded
   output logic [7:0] load_table, // table number applied
   output logic load_volatile, // table is in memory, not a file
   output logic [7:0] load_entry, // entry index written
   output logic [2:0] load_action, // entry action
   output logic [15:0] load_pulse, // entry pulse time
   output logic [31:0] load_preset, // entry preset count
   output logic [7:0] last_error // result of the last command: 01 refused, 00 accepted
);
   logic [3:0] cnt_r, cnt_nxt;
   logic done_r, done_nxt, ok_r, ok_nxt, load_r, load_nxt;
   logic [7:0] err_r, err_nxt;
   cmd_t ent_r, ent_nxt;
   logic bad;

   ////////////////////////////////////////////////////////////////
   // selector match and range checks against module limits
   assign bad = (link.cmd.module_selector != own_selector)
      || (link.cmd.action > `ACT_MAX)
      || (link.cmd.preset_count > `PRESET_MAX);

   // latency counter, completion pulse and table apply
   always_comb begin
      cnt_nxt = cnt_r;
      done_nxt = 1'b0;
      ok_nxt = ok_r;
      load_nxt = 1'b0;
      err_nxt = err_r;
      ent_nxt = ent_r;
      if (link.req && !done_r) begin
         if (cnt_r == `MODULE_LATENCY) begin
            cnt_nxt = 4'h0;
            done_nxt = 1'b1; // at least one scan after trigger
            ok_nxt = ~bad;
            err_nxt = bad ? 8'h01 : 8'h00;
            if (!bad) begin
               ent_nxt = link.cmd; // edit and reload as one step
               load_nxt = 1'b1;
            end
         end else begin
            cnt_nxt = cnt_r + 4'h1;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         cnt_r <= 4'h0;
         done_r <= 1'b0;
         ok_r <= 1'b0;
         load_r <= 1'b0;
         err_r <= 8'h00;
         ent_r <= '0;
      end else begin
         cnt_r <= cnt_nxt;
         done_r <= done_nxt;
         ok_r <= ok_nxt;
         load_r <= load_nxt;
         err_r <= err_nxt;
         ent_r <= ent_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////
   // outputs
   assign link.done = done_r;
   assign link.ok = ok_r;
   assign table_load = load_r;
   assign load_output = ent_r.output_sel;
   assign load_table = ent_r.table_num;
   assign load_volatile = (ent_r.op == OP_INIT_SINGLE);
   assign load_entry = ent_r.entry_idx;
   assign load_action = ent_r.action;
   assign load_pulse = ent_r.pulse_time;
   assign load_preset = ent_r.preset_count;
   assign last_error = err_r; // readable by a separate command
endmodule : preset_cmd_module
`default_nettype wire

// [preset_cmd_monitor.sv]
// interface checks for the preset command link
`timescale 1ns/10ps
`default_nettype none
module preset_cmd_monitor
   import preset_cmd_pkg::*;
(
   input wire logic clk_sys, // scan clock
   input wire logic reset_n, // async reset, active low
   input wire logic req, // command valid
   input wire cmd_t cmd, // command payload
   input wire logic done, // completion pulse
   input wire logic ok // accepted
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   ////////////////////////////////////////////////////////////////////////
   // handshake timing; fixed latency keeps the scan count predictable
   req_to_done_a: assert property ($rose(req) |-> !done ##4 done)
      else $error("done not four cycles after request");
   done_pulse_a: assert property (done |=> !done)
      else $error("done longer than one cycle");
   req_drop_a: assert property (done |=> !req)
      else $error("request held after done");
   done_req_a: assert property (done |-> req)
      else $error("done without request");
   cmd_hold_a: assert property (req && !done |=> $stable(cmd))
      else $error("payload moved in flight");
   ////////////////////////////////////////////////////////////////////////
   // acceptance only for legal fields; pulse time and init payload rules on every request
   act_range_a: assert property (done && ok |-> cmd.action <= 3'h5)
      else $error("bad action accepted");
   preset_range_a: assert property (done && ok |-> cmd.preset_count <= 32'h7FFF4020)
      else $error("bad preset accepted");
   pulse_zero_a: assert property (req && cmd.action != 3'h2 && cmd.action != 3'h3
      |-> cmd.pulse_time == 16'h0000)
      else $error("pulse time sent for non-pulse action");
   init_fields_a: assert property (req && cmd.op == OP_INIT_SINGLE
      |-> cmd.table_num == 8'h00 && cmd.entry_idx == 8'h00)
      else $error("init sent table or entry");
   cover property (done && ok);
   cover property (done && !ok);
   cover property (req && cmd.op == OP_INIT_SINGLE);
endmodule : preset_cmd_monitor
`default_nettype wire

// [preset_cmd_pkg.sv]
// types shared by the command sequencer and the module end
`default_nettype none
package preset_cmd_pkg;
   typedef enum logic [1:0] {
      OP_NONE,
      OP_EDIT_RELOAD,
      OP_INIT_SINGLE
   } op_t;
   typedef struct packed {
      op_t op;
      logic [7:0] module_selector;
      logic [1:0] output_sel;
      logic [7:0] table_num;
      logic [7:0] entry_idx;
      logic [2:0] action;
      logic [15:0] pulse_time;
      logic [31:0] preset_count;
   } cmd_t;
endpackage : preset_cmd_pkg
`default_nettype wire

// [preset_cmd_regs.svh]
// constants for the preset table command link
`ifndef PRESET_CMD_REGS_SVH
`define PRESET_CMD_REGS_SVH
`define ACT_SET 3'h0
`define ACT_RESET 3'h1
`define ACT_PULSE_ON 3'h2
`define ACT_PULSE_OFF 3'h3
`define ACT_TOGGLE 3'h4
`define ACT_RESET_COUNT 3'h5
`define ACT_MAX 3'h5
`define PRESET_MAX 32'h7FFF4020
`define OUTPUT_MAX 2'h3
`define MODULE_LATENCY 4'h3
`endif

// [preset_cmd_seq.sv]
// controller-side sequencer for the edit-and-reload and init-table commands
// Summary of operation
// - start edit only on rising enable
// - edit and reload in one transaction
// - completion never in the triggering scan
// - exactly one of success or error
// - error code read by separate command
// - action codes 0 to 5 as listed
// - pulse time used only for pulses
// - workspace owned by this instance only
// - selector, table, entry range 0-255
// - entry index zero is first entry
// - action code limited to 0-5
// - pulse time is unsigned 16-bit
// - preset 32-bit, limited range
// - one entry changed per command
// - edited table active only after reload
// - init builds one-entry volatile table
`timescale 1ns/10ps
`default_nettype none
`include "preset_cmd_regs.svh"
module preset_cmd_seq
   import preset_cmd_pkg::*;
(
   input wire logic clk_sys, // scan clock
   input wire logic reset_n, // async reset, active low
   input wire logic edit_en, // edit-and-reload enable
   input wire logic init_en, // init-table enable
   input wire logic [7:0] module_selector, // target module
   input wire logic [1:0] output_sel, // target output
   input wire logic [7:0] table_num, // table to edit
   input wire logic [7:0] entry_idx, // entry, zero based
   input wire logic [2:0] action, // entry action code
   input wire logic [15:0] pulse_time, // pulse duration
   input wire logic [31:0] preset_count, // preset count
   output logic busy, // command in flight
   output logic success, // completed and accepted
   output logic error, // completed and refused
   preset_cmd_if.ctrl link // to module
);
   // command state, result flags and the private workspace
   typedef enum logic {IDLE, WAIT} st_t;
   st_t st_r, st_nxt;
   logic success_r, success_nxt, error_r, error_nxt;
   cmd_t cmd_r, cmd_nxt; // workspace, private to this instance
   logic edit_rise, init_rise;
   logic start_edit, start_init, start_any;
   logic pulse_kind, finish;

   ////////////////////////////////////////////////////////////////
   // edge detect: a held enable never retriggers
   enable_rise i_enable_rise_edit (
      .clk_sys(clk_sys), // scan clock
      .reset_n(reset_n), // async reset
      .level(edit_en), // edit enable level
      .rise(edit_rise)
   );
   enable_rise i_enable_rise_init (
      .clk_sys(clk_sys), // scan clock
      .reset_n(reset_n), // async reset
      .level(init_en), // init enable level
      .rise(init_rise) // one scan per new request
   );

   ////////////////////////////////////////////////////////////////
   // trigger qualification; a rise while busy is dropped, not queued
   assign start_edit = (st_r == IDLE) && edit_rise;
   // edit wins if both rise together; the init request is lost
   assign start_init = (st_r == IDLE) && init_rise && !edit_rise;
   assign start_any = start_edit || start_init;
   // pulse time only matters for the two pulse actions
   assign pulse_kind = (action == `ACT_PULSE_ON) || (action == `ACT_PULSE_OFF);
   // the answer is only looked at while waiting, never in the trigger scan
   assign finish = (st_r == WAIT) && link.done;

   ////////////////////////////////////////////////////////////////
   // command state: idle until a trigger, waiting until the module answers
   always_comb begin
      st_nxt = st_r;
      unique case (st_r)
         IDLE: begin
            if (start_any) begin
               st_nxt = WAIT;
            end
         end
         WAIT: begin
            if (finish) begin
               st_nxt = IDLE;
            end
         end
      endcase
   end

   // state register
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         st_r <= IDLE;
      end else begin
         st_r <= st_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////
   // result flags: sticky until the next trigger clears them
   always_comb begin
      success_nxt = success_r;
      error_nxt = error_r;
      unique case (st_r)
         IDLE: begin
            if (start_any) begin
               success_nxt = 1'b0;
               error_nxt = 1'b0;
            end
         end
         WAIT: begin
            if (finish) begin
               success_nxt = link.ok;
               error_nxt = ~link.ok;
            end
         end
      endcase
   end

   // flag registers
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         success_r <= 1'b0;
         error_r <= 1'b0;
      end else begin
         success_r <= success_nxt;
         error_r <= error_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////
   // workspace: the payload is captured once on the trigger and held,
   // so the caller may move its inputs while the command runs
   always_comb begin
      cmd_nxt = cmd_r;
      unique case (st_r)
         IDLE: begin
            if (start_any) begin
               cmd_nxt.op = start_edit ? OP_EDIT_RELOAD : OP_INIT_SINGLE;
               cmd_nxt.module_selector = module_selector;
               cmd_nxt.output_sel = output_sel;
               // init builds a fresh one-entry table, so no table or entry is named
               cmd_nxt.table_num = start_edit ? table_num : 8'h00;
               cmd_nxt.entry_idx = start_edit ? entry_idx : 8'h00;
               cmd_nxt.action = action;
               cmd_nxt.pulse_time = pulse_kind ? pulse_time : 16'h0000;
               cmd_nxt.preset_count = preset_count;
            end
         end
         WAIT: begin
            if (finish) begin
               cmd_nxt.op = OP_NONE;
            end
         end
      endcase
   end

   // workspace register
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         cmd_r <= '0;
      end else begin
         cmd_r <= cmd_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////
   // outputs; error detail is fetched by a separate command
   // busy and req are the same state bit seen from two sides
   assign link.req = (st_r == WAIT);
   assign link.cmd = cmd_r;
   assign busy = (st_r == WAIT);
   assign success = success_r;
   assign error = error_r;
endmodule : preset_cmd_seq

////////////////////////////////////////////////////////////////
// rising-edge detector for a level enable from logic on the scan clock
// resets low, so an enable already high at release counts as a rise
module enable_rise (
   input wire logic clk_sys, // scan clock
   input wire logic reset_n, // async reset, active low
   input wire logic level, // enable level
   output logic rise // high in the scan the level first goes high
);
   logic last_r, last_nxt;

   // level seen at the previous scan
   always_comb begin
      last_nxt = level;
   end

   // history register
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         last_r <= 1'b0;
      end else begin
         last_r <= last_nxt;
      end
   end

   // one scan per low-to-high change; a held level gives nothing more
   assign rise = level & ~last_r;
endmodule : enable_rise
`default_nettype wire

// [preset_table_edit_init_cmd_tb.sv]
// self-checking bench for the preset command link
`timescale 1ns/10ps
`default_nettype none
module preset_table_edit_init_cmd_tb;
   logic clk_sys, reset_n, edit_en, init_en, busy, success, error, table_load, load_volatile;
   logic [7:0] module_selector, own_selector, table_num, entry_idx, load_table, load_entry;
   logic [7:0] last_error;
   logic [1:0] output_sel, load_output;
   logic [2:0] action, load_action;
   logic [15:0] pulse_time, load_pulse;
   logic [31:0] preset_count, load_preset;
   int fail_count = 0;
   int tests_run = 0;
   preset_cmd_if link ();
   preset_cmd_seq i_preset_cmd_seq (.clk_sys(clk_sys), .reset_n(reset_n), .edit_en(edit_en),
      .init_en(init_en), .module_selector(module_selector), .output_sel(output_sel),
      .table_num(table_num), .entry_idx(entry_idx), .action(action), .pulse_time(pulse_time),
      .preset_count(preset_count), .busy(busy), .success(success), .error(error), .link(link));
   preset_cmd_module i_preset_cmd_module (.clk_sys(clk_sys), .reset_n(reset_n),
      .own_selector(own_selector), .link(link), .table_load(table_load),
      .load_output(load_output), .load_table(load_table), .load_volatile(load_volatile),
      .load_entry(load_entry), .load_action(load_action), .load_pulse(load_pulse),
      .load_preset(load_preset), .last_error(last_error));
   preset_cmd_monitor i_preset_cmd_monitor (.clk_sys(clk_sys), .reset_n(reset_n),
      .req(link.req), .cmd(link.cmd), .done(link.done), .ok(link.ok));
   ////////////////////////////////////////////////////////////////////////
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task finish_test;
      if (fail_count == 0 && tests_run > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : finish_test
   // one command: trigger, wait bounded, compare flags and applied entry
   task run(input bit ed, input logic [7:0] sel, tb, en, input logic [2:0] act,
      input logic [15:0] pt, input logic [31:0] pc, input bit ok);
      int n;
      int loads;
      n = 0;
      loads = 0;
      @(posedge clk_sys);
      module_selector <= sel;
      output_sel <= 2'h2;
      table_num <= tb;
      entry_idx <= en;
      action <= act;
      pulse_time <= pt;
      preset_count <= pc;
      if (ed) edit_en <= 1'b1;
      else init_en <= 1'b1;
      @(posedge clk_sys);
      // move the inputs once the trigger is taken; the workspace must not follow
      table_num <= ~tb;
      entry_idx <= ~en;
      pulse_time <= ~pt;
      preset_count <= ~pc;
      @(negedge clk_sys);
      chk(success | error, 0);
      chk(busy, 1);
      while (!(success | error) && n < 20) begin
         if (table_load === 1'b1) loads++;
         n++;
         @(negedge clk_sys);
      end
      if (n == 20) begin
         fail_count++;
         finish_test();
      end
      chk(n, 5);
      chk({success, error}, {ok, !ok});
      chk(loads, ok);
      chk(last_error, ok ? 8'h00 : 8'h01);
      if (ok) begin
         chk(load_output, 2'h2);
         chk(load_table, ed ? tb : 8'h00);
         chk(load_entry, ed ? en : 8'h00);
         chk(load_volatile, !ed);
         chk(load_action, act);
         chk(load_pulse, (act == 3'h2 || act == 3'h3) ? pt : 16'h0000);
         chk(load_preset, pc);
      end
      // enable held high must not start another command
      repeat (3) @(negedge clk_sys);
      chk({busy, link.req}, 0);
      @(posedge clk_sys);
      edit_en <= 1'b0;
      init_en <= 1'b0;
   endtask : run
   ////////////////////////////////////////////////////////////////////////
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   initial begin
      reset_n = 1'b0;
      edit_en = 1'b0;
      init_en = 1'b0;
      own_selector = 8'h07;
      module_selector = 8'h00;
      output_sel = 2'h0;
      table_num = 8'h00;
      entry_idx = 8'h00;
      action = 3'h0;
      pulse_time = 16'h0000;
      preset_count = 32'h00000000;
      repeat (6) @(posedge clk_sys);
      reset_n <= 1'b1;
      run(1, 8'h07, 8'hFF, 8'hFF, 3'h2, 16'hFFFF, 32'h7FFF4020, 1);
      for (int a = 0; a < 6; a++) run(0, 8'h07, 8'h09, 8'h04, a[2:0], 16'h1234, 32'h19, 1);
      run(1, 8'h07, 8'h01, 8'h00, 3'h4, 16'h00FF, 32'h1E, 1);
      run(1, 8'h07, 8'h01, 8'h01, 3'h6, 16'h0000, 32'h1E, 0);
      run(1, 8'h07, 8'h01, 8'h01, 3'h0, 16'h0000, 32'h7FFF4021, 0);
      run(0, 8'h08, 8'h00, 8'h00, 3'h0, 16'h0000, 32'h0F, 0);
      finish_test();
   end
endmodule : preset_table_edit_init_cmd_tb
`default_nettype wire
